// file: design/ddrpi_pkg.sv
package ddrpi_pkg;

  localparam int DQ_W   = 32;
  localparam int LANES  = 4;
  localparam int LANE_W = 8;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int AP_BIT = 10;

  // Link clock phase counter: clock_true is high in phases 0 and 1
  localparam logic [1:0] PH_READY = 2'h0;
  localparam logic [1:0] PH_SLOT  = 2'h1;
  localparam logic [1:0] PH_LAST  = 2'h3;
  // Reset lands in a low phase so the first link clock pulse is full width
  localparam logic [1:0] PH_RST   = 2'h2;

  // Mode register select on bank_select during a load
  localparam logic [1:0] MR_STD = 2'h0;
  localparam logic [1:0] MR_EXT = 2'h2;

  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;

  // Write beat schedule, cycles after the command slot
  localparam logic [2:0] WR_D0  = 3'h2;
  localparam logic [2:0] WR_HI  = 3'h3;
  localparam logic [2:0] WR_D1  = 3'h4;
  localparam logic [2:0] WR_LO  = 3'h5;
  localparam logic [2:0] WR_END = 3'h6;

  // Read beat schedule, cycles after the command is taken
  localparam logic [2:0] RD_HI  = 3'h3;
  localparam logic [2:0] RD_W0E = 3'h4;
  localparam logic [2:0] RD_END = 3'h6;

  localparam logic [1:0] BURST_BEATS = 2'h2;

  typedef enum logic [2:0] {
    CMD_LMR  = 3'b000,
    CMD_AREF = 3'b001,
    CMD_PRE  = 3'b010,
    CMD_ACT  = 3'b011,
    CMD_WR   = 3'b100,
    CMD_RD   = 3'b101,
    CMD_BST  = 3'b110,
    CMD_NOP  = 3'b111
  } ddrpi_cmd_e;

  typedef enum logic [1:0] {
    PW_ACTIVE   = 2'b00,
    PW_PRE_PD   = 2'b01,
    PW_ACT_PD   = 2'b10,
    PW_SELF_REF = 2'b11
  } ddrpi_pwr_e;

endpackage : ddrpi_pkg

// file: design/ddrpi_link_if.sv
`timescale 1ns/1ps
interface ddrpi_link_if;
  logic                                  clock_true;
  logic                                  clock_complement;
  logic                                  clock_enable;
  logic                                  chip_select_n;
  logic                                  row_strobe_n;
  logic                                  column_strobe_n;
  logic                                  write_enable_n;
  logic [ddrpi_pkg::BANK_W-1:0]          bank_select;
  logic [ddrpi_pkg::ADDR_W-1:0]          address_bus;
  logic                                  extra_row_bit;
  logic [ddrpi_pkg::LANES-1:0]           write_byte_mask;
  logic [ddrpi_pkg::DQ_W-1:0]            ctl_dq_o;
  logic                                  ctl_dq_oe;
  logic [ddrpi_pkg::LANES-1:0]           ctl_dqs_o;
  logic                                  ctl_dqs_oe;
  logic [ddrpi_pkg::DQ_W-1:0]            mem_dq_o;
  logic                                  mem_dq_oe;
  logic [ddrpi_pkg::LANES-1:0]           mem_dqs_o;
  logic                                  mem_dqs_oe;
  logic [ddrpi_pkg::DQ_W-1:0]            data_lines;
  logic [ddrpi_pkg::LANES-1:0]           lane_data_strobe;

  // Undriven wire reads as zero
  assign data_lines = mem_dq_oe ? mem_dq_o : (ctl_dq_oe ? ctl_dq_o : {ddrpi_pkg::DQ_W{1'b0}});
  assign lane_data_strobe = mem_dqs_oe ? mem_dqs_o :
                            (ctl_dqs_oe ? ctl_dqs_o : {ddrpi_pkg::LANES{1'b0}});

  modport ctl (
    output clock_true, clock_complement, clock_enable, chip_select_n, row_strobe_n,
    output column_strobe_n, write_enable_n, bank_select, address_bus, extra_row_bit,
    output write_byte_mask, ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe,
    input  data_lines, lane_data_strobe
  );
  modport mem (
    input  clock_true, clock_complement, clock_enable, chip_select_n, row_strobe_n,
    input  column_strobe_n, write_enable_n, bank_select, address_bus, extra_row_bit,
    input  write_byte_mask, data_lines, lane_data_strobe,
    output mem_dq_o, mem_dq_oe, mem_dqs_o, mem_dqs_oe
  );
endinterface : ddrpi_link_if

// file: design/ddrpi_ctl_end.sv
`timescale 1ns/1ps
module ddrpi_ctl_end #(
  parameter bit HAS_EXTRA_ROW = 1'b0
) (
  input  wire logic                              clk,
  input  wire logic                              nrst,
  ddrpi_link_if.ctl                              link,
  input  wire logic                              req_valid,
  output logic                                   req_ready,
  input  wire ddrpi_pkg::ddrpi_cmd_e             req_cmd,
  input  wire logic [ddrpi_pkg::BANK_W-1:0]      req_bank,
  input  wire logic [ddrpi_pkg::ADDR_W-1:0]      req_addr,
  input  wire logic                              req_extra,
  input  wire logic [ddrpi_pkg::DQ_W-1:0]        req_wdata0,
  input  wire logic [ddrpi_pkg::DQ_W-1:0]        req_wdata1,
  input  wire logic [ddrpi_pkg::LANES-1:0]       req_wmask0,
  input  wire logic [ddrpi_pkg::LANES-1:0]       req_wmask1,
  input  wire logic                              cke_level,
  output logic                                   rd_valid,
  output logic [ddrpi_pkg::DQ_W-1:0]             rd_data0,
  output logic [ddrpi_pkg::DQ_W-1:0]             rd_data1
);
  typedef enum logic [1:0] {
    C_IDLE  = 2'b00,
    C_WAIT  = 2'b01,
    C_WDATA = 2'b10,
    C_RDATA = 2'b11
  } ddrpi_cst_e;

  localparam int SW = ddrpi_pkg::DQ_W + ddrpi_pkg::LANES;

  ddrpi_cst_e                     state_q;
  logic [1:0]                     ph_q;
  logic                           ready_q, accept, slot;
  logic                           ckt_q, ckc_q, cke_q, cs_n_q;
  ddrpi_pkg::ddrpi_cmd_e          cmd_q;
  logic [ddrpi_pkg::BANK_W-1:0]   ba_q;
  logic [ddrpi_pkg::ADDR_W-1:0]   addr_q;
  logic                           xrow_q;
  logic [ddrpi_pkg::DQ_W-1:0]     wd0_q, wd1_q, dq_q;
  logic [ddrpi_pkg::LANES-1:0]    wm1_q, dm_q, dqs_q;
  logic                           dq_oe_q, dqs_oe_q;
  logic [2:0]                     wcnt_q;
  logic [SW-1:0]                  s1_q, s2_q;
  logic                           dqs_s3_q, rd_edge;
  logic [1:0]                     beat_q;
  logic                           rv_q;
  logic [ddrpi_pkg::DQ_W-1:0]     rd0_q, rd1_q;

  assign slot   = (ph_q == ddrpi_pkg::PH_SLOT);
  assign accept = req_valid && ready_q;

  // Link clock is clk divided by four; commands change at the falling crossing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ph_q  <= ddrpi_pkg::PH_RST;
      ckt_q <= 1'b0;
      ckc_q <= 1'b1;
    end else begin
      ph_q  <= ph_q + 2'h1;
      ckt_q <= (ph_q == ddrpi_pkg::PH_LAST) || (ph_q == ddrpi_pkg::PH_READY);
      ckc_q <= !((ph_q == ddrpi_pkg::PH_LAST) || (ph_q == ddrpi_pkg::PH_READY));
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (ph_q == ddrpi_pkg::PH_READY) && (state_q == C_IDLE);
    end
  end

  // Command pins are held a whole link period, centred on the rising crossing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cke_q  <= 1'b1;
      cs_n_q <= 1'b1;
      cmd_q  <= ddrpi_pkg::CMD_NOP;
      ba_q   <= '0;
      addr_q <= '0;
      xrow_q <= 1'b0;
    end else if (accept) begin
      cke_q  <= cke_level;
      cs_n_q <= 1'b0;
      cmd_q  <= req_cmd;
      ba_q   <= req_bank;
      addr_q <= req_addr;
      xrow_q <= HAS_EXTRA_ROW ? req_extra : 1'b0;
    end else if (slot) begin
      cs_n_q <= 1'b1;
      cmd_q  <= ddrpi_pkg::CMD_NOP;
      if (state_q == C_IDLE) begin
        cke_q <= cke_level;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= C_IDLE;
    end else begin
      case (state_q)
        C_IDLE: begin
          if (accept) begin
            case (req_cmd)
              ddrpi_pkg::CMD_WR: state_q <= C_WDATA;
              ddrpi_pkg::CMD_RD: state_q <= C_RDATA;
              default:           state_q <= C_WAIT;
            endcase
          end
        end
        C_WAIT: begin
          if (slot) begin
            state_q <= C_IDLE;
          end
        end
        C_WDATA: begin
          if (wcnt_q == ddrpi_pkg::WR_END) begin
            state_q <= C_IDLE;
          end
        end
        C_RDATA: begin
          if (slot && beat_q == ddrpi_pkg::BURST_BEATS) begin
            state_q <= C_IDLE;
          end
        end
        default: state_q <= C_IDLE;
      endcase
    end
  end

  // Write burst: strobe edges fall in the middle of each data eye
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wcnt_q   <= 3'h0;
      dq_q     <= '0;
      dm_q     <= '0;
      dqs_q    <= '0;
      dq_oe_q  <= 1'b0;
      dqs_oe_q <= 1'b0;
      wd0_q    <= '0;
      wd1_q    <= '0;
      wm1_q    <= '0;
    end else if (accept && req_cmd == ddrpi_pkg::CMD_WR) begin
      wcnt_q   <= 3'h1;
      dqs_oe_q <= 1'b1;
      dqs_q    <= '0;
      wd0_q    <= req_wdata0;
      wd1_q    <= req_wdata1;
      dm_q     <= req_wmask0;
      wm1_q    <= req_wmask1;
    end else if (state_q == C_WDATA) begin
      wcnt_q <= wcnt_q + 3'h1;
      case (wcnt_q)
        ddrpi_pkg::WR_D0: begin
          dq_q    <= wd0_q;
          dq_oe_q <= 1'b1;
        end
        ddrpi_pkg::WR_HI: dqs_q <= '1;
        ddrpi_pkg::WR_D1: begin
          dq_q <= wd1_q;
          dm_q <= wm1_q;
        end
        ddrpi_pkg::WR_LO: dqs_q <= '0;
        ddrpi_pkg::WR_END: begin
          dq_oe_q  <= 1'b0;
          dqs_oe_q <= 1'b0;
          dm_q     <= '0;
        end
        default: wcnt_q <= wcnt_q + 3'h1;
      endcase
    end
  end

  // Inbound data and strobe are asynchronous pins: two flops first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q     <= '0;
      s2_q     <= '0;
      dqs_s3_q <= 1'b0;
    end else begin
      s1_q     <= {link.data_lines, link.lane_data_strobe};
      s2_q     <= s1_q;
      dqs_s3_q <= s2_q[0];
    end
  end

  assign rd_edge = s2_q[0] ^ dqs_s3_q;

  // Read strobe is edge aligned, so data is taken with the synchronised edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      beat_q <= 2'h0;
      rd0_q  <= '0;
      rd1_q  <= '0;
      rv_q   <= 1'b0;
    end else begin
      rv_q <= 1'b0;
      if (state_q != C_RDATA) begin
        beat_q <= 2'h0;
      end else if (rd_edge && beat_q < ddrpi_pkg::BURST_BEATS) begin
        beat_q <= beat_q + 2'h1;
        if (beat_q == 2'h0) begin
          rd0_q <= s2_q[SW-1 -: ddrpi_pkg::DQ_W];
        end else begin
          rd1_q <= s2_q[SW-1 -: ddrpi_pkg::DQ_W];
        end
      end else if (slot && beat_q == ddrpi_pkg::BURST_BEATS) begin
        rv_q <= 1'b1;
      end
    end
  end

  assign link.clock_true       = ckt_q;
  assign link.clock_complement = ckc_q;
  assign link.clock_enable     = cke_q;
  assign link.chip_select_n    = cs_n_q;
  assign link.row_strobe_n     = cmd_q[2];
  assign link.column_strobe_n  = cmd_q[1];
  assign link.write_enable_n   = cmd_q[0];
  assign link.bank_select      = ba_q;
  assign link.address_bus      = addr_q;
  assign link.extra_row_bit    = xrow_q;
  assign link.write_byte_mask  = dm_q;
  assign link.ctl_dq_o         = dq_q;
  assign link.ctl_dq_oe        = dq_oe_q;
  assign link.ctl_dqs_o        = dqs_q;
  assign link.ctl_dqs_oe       = dqs_oe_q;
  assign req_ready             = ready_q;
  assign rd_valid              = rv_q;
  assign rd_data0              = rd0_q;
  assign rd_data1              = rd1_q;

endmodule : ddrpi_ctl_end

// file: design/ddrpi_mem_end.sv
`timescale 1ns/1ps
module ddrpi_mem_end #(
  parameter bit HAS_EXTRA_ROW = 1'b0,
  parameter int COL_IDX_W     = 2
) (
  input  wire logic                              clk,
  input  wire logic                              nrst,
  ddrpi_link_if.mem                              link,
  output ddrpi_pkg::ddrpi_pwr_e                  power_state,
  output logic [(1 << ddrpi_pkg::BANK_W)-1:0]    bank_open,
  output logic [ddrpi_pkg::ADDR_W:0]             active_row,
  output logic [ddrpi_pkg::ADDR_W-1:0]           mode_std,
  output logic [ddrpi_pkg::ADDR_W-1:0]           mode_ext
);
  localparam int NBANK = 1 << ddrpi_pkg::BANK_W;
  localparam int IDX_W = ddrpi_pkg::BANK_W + COL_IDX_W;
  localparam int WORDS = 1 << IDX_W;
  localparam int SW    = 7 + ddrpi_pkg::BANK_W + ddrpi_pkg::ADDR_W + 1 + 2 * ddrpi_pkg::LANES
                         + ddrpi_pkg::DQ_W;

  logic [SW-1:0]                  s1_q, s2_q;
  logic                           cke_s, ckt_s, ckc_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, xrow_s;
  logic [ddrpi_pkg::BANK_W-1:0]   ba_s;
  logic [ddrpi_pkg::ADDR_W-1:0]   addr_s;
  logic [ddrpi_pkg::LANES-1:0]    dm_s, dqs_s, dqs_s3_q, dqs_edge;
  logic [ddrpi_pkg::DQ_W-1:0]     dq_s;
  logic                           ckt_s3_q, link_rise, take;
  ddrpi_pkg::ddrpi_cmd_e          cmd;
  ddrpi_pkg::ddrpi_pwr_e          pwr_q;
  logic [NBANK-1:0]               open_q;
  logic [ddrpi_pkg::ADDR_W:0]     row_q;
  logic [ddrpi_pkg::ADDR_W-1:0]   std_q, ext_q;
  logic [IDX_W-1:0]               idx, wr_idx_q;
  logic [ddrpi_pkg::DQ_W-1:0]     store_q [WORDS];
  logic                           wr_pend_q, wr_beat_q;
  logic [2:0]                     rd_cnt_q;
  logic [ddrpi_pkg::DQ_W-1:0]     rw0_q, rw1_q, dq_q;
  logic                           dq_oe_q, dqs_q;

  // Every pin is asynchronous to clk: two flops before any logic
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q     <= '0;
      s2_q     <= '0;
      ckt_s3_q <= 1'b0;
      dqs_s3_q <= '0;
    end else begin
      s1_q     <= {link.clock_enable, link.clock_true, link.clock_complement,
                   link.chip_select_n, link.row_strobe_n, link.column_strobe_n,
                   link.write_enable_n, link.bank_select, link.address_bus,
                   link.extra_row_bit, link.write_byte_mask, link.data_lines,
                   link.lane_data_strobe};
      s2_q     <= s1_q;
      ckt_s3_q <= ckt_s;
      dqs_s3_q <= dqs_s;
    end
  end

  assign {cke_s, ckt_s, ckc_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, xrow_s,
          dm_s, dq_s, dqs_s} = s2_q;

  assign link_rise = ckt_s && !ckt_s3_q && !ckc_s;
  assign cmd      = ddrpi_pkg::ddrpi_cmd_e'({ras_n_s, cas_n_s, we_n_s});
  // Decoder runs only when powered up, enabled and selected
  assign take     = link_rise && cke_s && (pwr_q == ddrpi_pkg::PW_ACTIVE) && !cs_n_s;
  assign idx      = {ba_s, addr_s[COL_IDX_W-1:0]};
  assign dqs_edge = dqs_s ^ dqs_s3_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwr_q <= ddrpi_pkg::PW_ACTIVE;
    end else begin
      case (pwr_q)
        ddrpi_pkg::PW_ACTIVE: begin
          if (link_rise && !cke_s) begin
            if (!cs_n_s && cmd == ddrpi_pkg::CMD_AREF) begin
              pwr_q <= ddrpi_pkg::PW_SELF_REF;
            end else if (|open_q) begin
              pwr_q <= ddrpi_pkg::PW_ACT_PD;
            end else begin
              pwr_q <= ddrpi_pkg::PW_PRE_PD;
            end
          end
        end
        ddrpi_pkg::PW_PRE_PD, ddrpi_pkg::PW_ACT_PD: begin
          if (link_rise && cke_s) begin
            pwr_q <= ddrpi_pkg::PW_ACTIVE;
          end
        end
        // The clock may be stopped here, so exit needs no clock crossing
        ddrpi_pkg::PW_SELF_REF: begin
          if (cke_s) begin
            pwr_q <= ddrpi_pkg::PW_ACTIVE;
          end
        end
        default: pwr_q <= ddrpi_pkg::PW_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      open_q <= '0;
      row_q  <= '0;
    end else if (take) begin
      case (cmd)
        ddrpi_pkg::CMD_ACT: begin
          open_q[ba_s] <= 1'b1;
          row_q        <= {HAS_EXTRA_ROW ? xrow_s : 1'b0, addr_s};
        end
        ddrpi_pkg::CMD_PRE: begin
          if (addr_s[ddrpi_pkg::AP_BIT]) begin
            open_q <= '0;
          end else begin
            open_q[ba_s] <= 1'b0;
          end
        end
        ddrpi_pkg::CMD_RD, ddrpi_pkg::CMD_WR: begin
          if (addr_s[ddrpi_pkg::AP_BIT]) begin
            open_q[ba_s] <= 1'b0;
          end
        end
        default: open_q <= open_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      std_q <= ddrpi_pkg::MODE_RST;
      ext_q <= ddrpi_pkg::MODE_RST;
    end else if (take && cmd == ddrpi_pkg::CMD_LMR) begin
      if (ba_s == ddrpi_pkg::MR_STD) begin
        std_q <= addr_s;
      end else if (ba_s == ddrpi_pkg::MR_EXT) begin
        ext_q <= addr_s;
      end
    end
  end

  // Write capture on both strobe edges; only unmasked lanes are stored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_beat_q <= 1'b0;
      wr_idx_q  <= '0;
    end else if (take && cmd == ddrpi_pkg::CMD_WR) begin
      wr_pend_q <= 1'b1;
      wr_beat_q <= 1'b0;
      wr_idx_q  <= idx;
    end else if (wr_pend_q && dqs_edge[0]) begin
      wr_beat_q <= 1'b1;
      wr_pend_q <= !wr_beat_q;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < ddrpi_pkg::LANES; i++) begin
      if (wr_pend_q && dqs_edge[i] && !dm_s[i]) begin
        store_q[wr_idx_q ^ IDX_W'(wr_beat_q)][i*ddrpi_pkg::LANE_W +: ddrpi_pkg::LANE_W]
          <= dq_s[i*ddrpi_pkg::LANE_W +: ddrpi_pkg::LANE_W];
      end
    end
  end

  // Read burst: preamble with word 0 already driven; data changes to word 1 with the falling strobe edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_cnt_q <= 3'h0;
      rw0_q    <= '0;
      rw1_q    <= '0;
    end else if (!cke_s) begin
      rd_cnt_q <= 3'h0;
    end else if (take && cmd == ddrpi_pkg::CMD_RD) begin
      rd_cnt_q <= 3'h1;
      rw0_q    <= store_q[idx];
      rw1_q    <= store_q[idx ^ IDX_W'(1)];
    end else if (rd_cnt_q == ddrpi_pkg::RD_END) begin
      rd_cnt_q <= 3'h0;
    end else if (rd_cnt_q != 3'h0) begin
      rd_cnt_q <= rd_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_oe_q <= 1'b0;
      dqs_q   <= 1'b0;
      dq_q    <= '0;
    end else begin
      dq_oe_q <= cke_s && (rd_cnt_q != 3'h0);
      dqs_q   <= (rd_cnt_q == ddrpi_pkg::RD_HI) || (rd_cnt_q == ddrpi_pkg::RD_W0E);
      dq_q    <= (rd_cnt_q <= ddrpi_pkg::RD_W0E) ? rw0_q : rw1_q;
    end
  end

  assign link.mem_dq_o   = dq_q;
  assign link.mem_dq_oe  = dq_oe_q;
  assign link.mem_dqs_o  = {ddrpi_pkg::LANES{dqs_q}};
  assign link.mem_dqs_oe = dq_oe_q;
  assign power_state     = pwr_q;
  assign bank_open       = open_q;
  assign active_row      = row_q;
  assign mode_std        = std_q;
  assign mode_ext        = ext_q;

endmodule : ddrpi_mem_end

// file: test/ddrpi_monitor.sv
`timescale 1ns/1ps
module ddrpi_monitor (
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire logic                        clock_true,
  input wire logic                        clock_complement,
  input wire logic                        chip_select_n,
  input wire logic                        row_strobe_n,
  input wire logic                        column_strobe_n,
  input wire logic                        write_enable_n,
  input wire logic                        extra_row_bit,
  input wire logic                        ctl_dq_oe,
  input wire logic                        ctl_dqs_oe,
  input wire logic [ddrpi_pkg::LANES-1:0] ctl_dqs_o,
  input wire logic                        mem_dq_oe,
  input wire logic                        mem_dqs_oe,
  input wire logic [ddrpi_pkg::LANES-1:0] mem_dqs_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_STROBE_OWNER: assert property (!(ctl_dqs_oe && mem_dqs_oe))
    else $error("both ends drive the strobes");
  AST_DATA_OWNER: assert property (!(ctl_dq_oe && mem_dq_oe))
    else $error("both ends drive the data lines");
  AST_CLK_PAIR: assert property (clock_complement == !clock_true)
    else $error("clock pair not complementary");
  AST_CLK_RATE: assert property ($rose(clock_true) |=>
    clock_true ##1 !clock_true ##1 !clock_true ##1 clock_true)
    else $error("link clock not a quarter of clk");
  AST_CS_WIDTH: assert property ($fell(chip_select_n) |->
    !chip_select_n [*4] ##1 chip_select_n)
    else $error("chip select low not one link period");
  AST_WR_DRIVE: assert property ($fell(chip_select_n) &&
    {row_strobe_n, column_strobe_n, write_enable_n} == 3'h4 |-> ctl_dqs_oe ##2 ctl_dq_oe)
    else $error("write command without controller drive");
  // Lane 0 stands for all lanes since the strobes move together
  AST_WR_CENTRE: assert property ($rose(ctl_dq_oe) |-> !ctl_dqs_o[0] ##1
    ctl_dqs_o[0] [*2] ##1 !ctl_dqs_o[0] ##1 (!ctl_dq_oe && !ctl_dqs_oe))
    else $error("write strobe not centred or not released");
  AST_RD_EDGE: assert property ($rose(mem_dqs_oe) |-> !mem_dqs_o[0] [*2] ##1
    mem_dqs_o[0] [*2] ##1 !mem_dqs_o[0] [*2] ##1 !mem_dqs_oe)
    else $error("read strobe sequence wrong");
  AST_EXTRA_IDLE: assert property (extra_row_bit == 1'b0)
    else $error("extra row bit used without the option");
endmodule : ddrpi_monitor

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                  clk, nrst, req_valid, req_ready, req_extra, cke_level, rd_valid;
  ddrpi_pkg::ddrpi_cmd_e req_cmd;
  ddrpi_pkg::ddrpi_pwr_e power_state;
  logic [1:0]            req_bank;
  logic [12:0]           req_addr, mode_std, mode_ext;
  logic [13:0]           active_row;
  logic [31:0]           req_wdata0, req_wdata1, rd_data0, rd_data1;
  logic [3:0]            req_wmask0, req_wmask1, bank_open;
  int                    mismatches, checks;

  typedef struct {
    logic [1:0] b; logic [12:0] c; logic [31:0] w0, w1; logic [3:0] m0, m1; logic [31:0] e0, e1;
  } ddrpi_row_s;
  // Rows build on each other: storage keeps no reset value
  ddrpi_row_s rows [5] = '{
    '{2'h0, 13'h0, 32'h11111111, 32'h22222222, 4'h0, 4'h0, 32'h11111111, 32'h22222222},
    '{2'h0, 13'h0, 32'haaaaaaaa, 32'hbbbbbbbb, 4'h1, 4'h8, 32'haaaaaa11, 32'h22bbbbbb},
    '{2'h0, 13'h1, 32'h33333333, 32'h44444444, 4'he, 4'h6, 32'h22bbbb33, 32'h44aaaa44},
    '{2'h3, 13'h2, 32'h5a5a5a5a, 32'ha5a5a5a5, 4'h0, 4'h0, 32'h5a5a5a5a, 32'ha5a5a5a5},
    '{2'h0, 13'h0, 32'h12345678, 32'h9abcdef0, 4'hf, 4'hf, 32'h44aaaa44, 32'h22bbbb33}};

  ddrpi_link_if u_ddrpi_link_if ();
  ddrpi_ctl_end u_ddrpi_ctl_end (.clk(clk), .nrst(nrst), .link(u_ddrpi_link_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank),
    .req_addr(req_addr), .req_extra(req_extra), .req_wdata0(req_wdata0),
    .req_wdata1(req_wdata1), .req_wmask0(req_wmask0), .req_wmask1(req_wmask1),
    .cke_level(cke_level), .rd_valid(rd_valid), .rd_data0(rd_data0), .rd_data1(rd_data1));
  ddrpi_mem_end u_ddrpi_mem_end (.clk(clk), .nrst(nrst), .link(u_ddrpi_link_if),
    .power_state(power_state), .bank_open(bank_open), .active_row(active_row),
    .mode_std(mode_std), .mode_ext(mode_ext));
  ddrpi_monitor u_ddrpi_monitor (.clk(clk), .nrst(nrst),
    .clock_true(u_ddrpi_link_if.clock_true), .clock_complement(u_ddrpi_link_if.clock_complement),
    .chip_select_n(u_ddrpi_link_if.chip_select_n), .row_strobe_n(u_ddrpi_link_if.row_strobe_n),
    .column_strobe_n(u_ddrpi_link_if.column_strobe_n),
    .write_enable_n(u_ddrpi_link_if.write_enable_n), .extra_row_bit(u_ddrpi_link_if.extra_row_bit),
    .ctl_dq_oe(u_ddrpi_link_if.ctl_dq_oe), .ctl_dqs_oe(u_ddrpi_link_if.ctl_dqs_oe),
    .ctl_dqs_o(u_ddrpi_link_if.ctl_dqs_o), .mem_dq_oe(u_ddrpi_link_if.mem_dq_oe),
    .mem_dqs_oe(u_ddrpi_link_if.mem_dqs_oe), .mem_dqs_o(u_ddrpi_link_if.mem_dqs_o));

  always #4 clk = ~clk;

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic hang();
    mismatches++;
    conclude();
  endtask : hang

  // Called at a falling edge; returns nine falling edges after the taking edge
  task automatic req(ddrpi_pkg::ddrpi_cmd_e c, logic [1:0] b, logic [12:0] a,
    logic [31:0] w0 = 32'h0, logic [31:0] w1 = 32'h0,
    logic [3:0] m0 = 4'h0, logic [3:0] m1 = 4'h0);
    int n;
    req_cmd = c;
    {req_bank, req_addr, req_wdata0, req_wdata1, req_wmask0, req_wmask1} =
      {b, a, w0, w1, m0, m1};
    req_valid = 1'b1;
    for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clk);
    if (n == 40) hang();
    @(negedge clk);
    req_valid = 1'b0;
    repeat (8) @(negedge clk);
  endtask : req

  task automatic rd(logic [1:0] b, logic [12:0] a);
    int n;
    req(ddrpi_pkg::CMD_RD, b, a);
    for (n = 0; n < 40 && rd_valid !== 1'b1; n++) @(negedge clk);
    if (n == 40) hang();
  endtask : rd

  task automatic wait_pwr(ddrpi_pkg::ddrpi_pwr_e e);
    int n;
    for (n = 0; n < 40 && power_state !== e; n++) @(negedge clk);
    if (n == 40) hang();
    check("power_state", power_state, e);
  endtask : wait_pwr

  initial begin
    {clk, nrst, req_valid, req_extra, req_bank, req_addr} = '0;
    {req_wdata0, req_wdata1, req_wmask0, req_wmask1} = '0;
    req_cmd = ddrpi_pkg::CMD_NOP;
    cke_level = 1'b1;
    repeat (8) @(negedge clk);
    check("req_ready", req_ready, 32'h0);
    check("rd_valid", rd_valid, 32'h0);
    check("power_state", power_state, ddrpi_pkg::PW_ACTIVE);
    check("mode_std", mode_std, ddrpi_pkg::MODE_RST);
    nrst = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      req(ddrpi_pkg::CMD_WR, rows[i].b, rows[i].c, rows[i].w0, rows[i].w1, rows[i].m0, rows[i].m1);
      rd(rows[i].b, rows[i].c);
      check("rd_data0", rd_data0, rows[i].e0);
      check("rd_data1", rd_data1, rows[i].e1);
    end
    $display("test data rows done");
    req(ddrpi_pkg::CMD_ACT, 2'h3, 13'h0123);
    req_extra = 1'b1;
    req(ddrpi_pkg::CMD_ACT, 2'h1, 13'h1abc);
    req_extra = 1'b0;
    check("active_row", active_row, 32'h1abc);
    check("bank_open", bank_open, 32'ha);
    req(ddrpi_pkg::CMD_PRE, 2'h1, 13'h0000);
    check("bank_open", bank_open, 32'h8);
    req(ddrpi_pkg::CMD_PRE, 2'h0, 13'h0400);
    check("bank_open", bank_open, 32'h0);
    req(ddrpi_pkg::CMD_LMR, 2'h0, 13'h0032);
    req(ddrpi_pkg::CMD_LMR, 2'h2, 13'h0155);
    req(ddrpi_pkg::CMD_LMR, 2'h1, 13'h1fff);
    check("mode_std", mode_std, 32'h0032);
    check("mode_ext", mode_ext, 32'h0155);
    $display("test commands done");
    cke_level = 1'b0;
    wait_pwr(ddrpi_pkg::PW_PRE_PD);
    req(ddrpi_pkg::CMD_ACT, 2'h3, 13'h0007);
    cke_level = 1'b1;
    wait_pwr(ddrpi_pkg::PW_ACTIVE);
    check("bank_open", bank_open, 32'h0);
    req(ddrpi_pkg::CMD_ACT, 2'h2, 13'h0055);
    cke_level = 1'b0;
    wait_pwr(ddrpi_pkg::PW_ACT_PD);
    cke_level = 1'b1;
    wait_pwr(ddrpi_pkg::PW_ACTIVE);
    req(ddrpi_pkg::CMD_PRE, 2'h0, 13'h0400);
    cke_level = 1'b0;
    req(ddrpi_pkg::CMD_AREF, 2'h0, 13'h0000);
    wait_pwr(ddrpi_pkg::PW_SELF_REF);
    cke_level = 1'b1;
    wait_pwr(ddrpi_pkg::PW_ACTIVE);
    $display("test power done");
    req(ddrpi_pkg::CMD_ACT, 2'h1, 13'h0001);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    check("bank_open", bank_open, 32'h0);
    check("mode_ext", mode_ext, ddrpi_pkg::MODE_RST);
    nrst = 1'b1;
    rd(2'h3, 13'h2);
    check("rd_data0", rd_data0, 32'h5a5a5a5a);
    check("rd_data1", rd_data1, 32'ha5a5a5a5);
    $display("test second reset done");
    conclude();
  end
endmodule : tb_top
